//--- hw/sdc_params.svh
// Constants of the delta-sigma clocking and decimation core: offsets, fields, resets, timing.
// Assumes a single 10 MHz pclk shared by both ends of the link.
//
// Summary of operation
// - Modulator clock is master clock divided 4/16
// - Divider chosen so modulator always runs 128 kHz
// - Each channel has own sinc3 decimator
// - One global rate field sets decimation ratio
// - Response is cube of boxcar over N
// - Notches at data rate and its multiples
// - Step input settles after three output periods
// - First output only after settling following start
// - Select pin low external clock, high oscillator
// - Oscillator drives clock pin only when enabled
// - External clock 512 kHz or 2.048 MHz
// - Reset assumes 512 kHz, divide by four
// - Host paces register access to clock rate
// - Setup bit powers down reference buffer
// - Wake up with reference buffer powered down
// - High reference only allowed on 5 V supply
// - Host runs external clock only when enabled and select pin low
// - Outputs 24-bit twos complement, clipped
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
`define SDC_PCLK_HZ        10000000
`define SDC_FCLK_LO_HZ     512000
`define SDC_FCLK_HI_HZ     2048000
`define SDC_OSC_HALF_CYC   (`SDC_PCLK_HZ / (2 * `SDC_FCLK_LO_HZ))
`define SDC_EXT_HALF_LO    (`SDC_PCLK_HZ / (2 * `SDC_FCLK_LO_HZ))
`define SDC_EXT_HALF_HI    (`SDC_PCLK_HZ / (2 * `SDC_FCLK_HI_HZ))
`define SDC_ACCESS_BITS    16
`define SDC_GAP_LO_CYC     ((`SDC_ACCESS_BITS * `SDC_PCLK_HZ + 2 * `SDC_FCLK_LO_HZ - 1) / (2 * `SDC_FCLK_LO_HZ))
`define SDC_GAP_HI_CYC     ((`SDC_ACCESS_BITS * `SDC_PCLK_HZ + 2 * `SDC_FCLK_HI_HZ - 1) / (2 * `SDC_FCLK_HI_HZ))
`define SDC_DIV_LO         5'h04
`define SDC_DIV_HI         5'h10
`define SDC_DEC_MAX        11'h400
`define SDC_SETTLE_OUT     2'h3
`define SDC_POS_FS         24'h7fffff
`define SDC_NEG_FS         24'h800000

////////////////////////////////////////////////////////////////////////////////
// Device register indices on the link register port
`define SDC_IDX_SETUP_A    4'h1
`define SDC_IDX_SETUP_B    4'h2
`define SDC_IDX_ESTAT      4'h8
`define SDC_SETUP_A_RST    8'h00
`define SDC_SETUP_B_RST    8'h80
`define SDC_ESTAT_RST      8'h00
`define SDC_A_RATE_LSB     0
`define SDC_B_PD_BIT       7
`define SDC_B_HIREF_BIT    5
`define SDC_B_OSCOUT_BIT   4
`define SDC_ESTAT_DIV_BIT  6

////////////////////////////////////////////////////////////////////////////////
// Host APB map
`define SDC_APB_CTRL       8'h00
`define SDC_APB_CMD        8'h04
`define SDC_APB_STATUS     8'h08
`define SDC_APB_DATA0      8'h0c
`define SDC_APB_DATA1      8'h10
`define SDC_CTRL_START     0
`define SDC_CTRL_CLOCK_SOURCE_SELECT_PIN    1
`define SDC_CTRL_EXT_RUN   2
`define SDC_CTRL_EXT_FAST  3
`define SDC_CMD_READ_BIT   12

`endif

//--- hw/sdc_pkg.sv
// Types shared by both ends of the delta-sigma core.
// Assumes sdc_params.svh holds all numeric constants.
package sdc_pkg;
   typedef logic signed [23:0] sdc_word_t;
   typedef logic signed [31:0] sdc_acc_t;
   typedef enum logic [1:0] {h_idle, h_wait, h_gap} sdc_host_state_t;
endpackage : sdc_pkg

//--- hw/sdc_link_if.sv
// Link between the converter core and its host controller.
// Assumes both ends share pclk; the clock pin level is resolved here.
interface sdc_link_if;
   logic              clock_source_select_pin;
   logic              start;
   logic              reg_wr;
   logic              reg_rd;
   logic [3:0]        reg_addr;
   logic [7:0]        reg_wdata;
   logic [7:0]        reg_rdata;
   logic              reg_ack;
   logic              data_ready;
   sdc_pkg::sdc_word_t ch0_word;
   sdc_pkg::sdc_word_t ch1_word;
   logic              dev_clk_out;
   logic              dev_clk_oe_n;
   logic              host_clk_out;
   logic              host_clk_oe_n;
   logic              clk_pin;

   // Undriven pin reads low
   assign clk_pin = !dev_clk_oe_n ? dev_clk_out : (!host_clk_oe_n ? host_clk_out : 1'b0);

   modport dev (input clock_source_select_pin, start, reg_wr, reg_rd, reg_addr, reg_wdata,
                clk_pin, output reg_rdata, reg_ack, data_ready, ch0_word, ch1_word,
                dev_clk_out, dev_clk_oe_n);
   modport host (output clock_source_select_pin, start, reg_wr, reg_rd, reg_addr, reg_wdata,
                 host_clk_out, host_clk_oe_n, input reg_rdata, reg_ack, data_ready,
                 ch0_word, ch1_word, clk_pin);
endinterface : sdc_link_if

//--- hw/sdc_dev_end.sv
// Converter core: clock source and modulator divider, two sinc3 decimators,
// reference control bits and the small register file behind the link port.
// Assumes the modulator bits arrive synchronous to pclk and the host paces accesses.
//
// Decided for this implementation: the APB slave port and the register offsets.
`include "sdc_params.svh"

module sdc_dev_end
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   sdc_link_if.dev         link,
   input  wire logic [1:0] mod_bits,
   output logic            modulator_tick,
   output logic            reference_buffer_powerdown,
   output logic            high_reference_select
);

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [10:0] sdc_dec_ratio(input logic [2:0] rate_select_field);
      sdc_dec_ratio = `SDC_DEC_MAX >> rate_select_field;
   endfunction : sdc_dec_ratio

   function automatic sdc_pkg::sdc_word_t sdc_clip(input sdc_pkg::sdc_acc_t v);
      if (v > $signed({8'h00, `SDC_POS_FS}))
         sdc_clip = `SDC_POS_FS;
      else if (v < $signed({8'hff, `SDC_NEG_FS}))
         sdc_clip = `SDC_NEG_FS;
      else
         sdc_clip = v[23:0];
   endfunction : sdc_clip

   ////////////////////////////////////////////////////////////////////////////////
   // Register file
   logic [7:0] global_setup_reg_a;
   logic [7:0] global_setup_reg_b;
   logic [7:0] electrode_status_reg;
   logic [7:0] rdata_reg;
   logic       ack_reg;
   logic [7:0] rd_mux;

   assign rd_mux = (link.reg_addr == `SDC_IDX_SETUP_A) ? global_setup_reg_a :
                   (link.reg_addr == `SDC_IDX_SETUP_B) ? global_setup_reg_b :
                   (link.reg_addr == `SDC_IDX_ESTAT)   ? electrode_status_reg : 8'h00;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         global_setup_reg_a   <= `SDC_SETUP_A_RST;
         global_setup_reg_b   <= `SDC_SETUP_B_RST;
         electrode_status_reg <= `SDC_ESTAT_RST;
         rdata_reg            <= 8'h00;
         ack_reg              <= 1'b0;
         reference_buffer_powerdown <= 1'b1;
         high_reference_select      <= 1'b0;
      end
      else
      begin
         ack_reg <= link.reg_wr | link.reg_rd;
         reference_buffer_powerdown <= global_setup_reg_b[`SDC_B_PD_BIT];
         high_reference_select      <= global_setup_reg_b[`SDC_B_HIREF_BIT];
         if (link.reg_rd)
            rdata_reg <= rd_mux;
         if (link.reg_wr && link.reg_addr == `SDC_IDX_SETUP_A)
            global_setup_reg_a <= link.reg_wdata;
         if (link.reg_wr && link.reg_addr == `SDC_IDX_SETUP_B)
            global_setup_reg_b <= link.reg_wdata;
         if (link.reg_wr && link.reg_addr == `SDC_IDX_ESTAT)
            electrode_status_reg <= link.reg_wdata;
      end
   end

   assign link.reg_rdata = rdata_reg;
   assign link.reg_ack   = ack_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock source: internal oscillator modelled as a pclk divider
   logic [4:0] osc_cnt_reg;
   logic       osc_reg;
   logic       pin_prev_reg;
   logic       osc_rise;
   logic       ext_rise;
   logic       master_edge;
   logic       osc_wrap;
   logic       use_osc;
   logic       osc_drive;

   assign use_osc     = link.clock_source_select_pin;
   assign osc_drive   = use_osc & global_setup_reg_b[`SDC_B_OSCOUT_BIT];
   assign osc_wrap    = (osc_cnt_reg == 5'(`SDC_OSC_HALF_CYC - 1));
   assign osc_rise    = osc_wrap & ~osc_reg;
   assign ext_rise    = link.clk_pin & ~pin_prev_reg;
   assign master_edge = use_osc ? osc_rise : ext_rise;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_cnt_reg       <= 5'h00;
         osc_reg           <= 1'b0;
         pin_prev_reg      <= 1'b0;
         link.dev_clk_out  <= 1'b0;
         link.dev_clk_oe_n <= 1'b1;
      end
      else
      begin
         osc_cnt_reg       <= osc_wrap ? 5'h00 : osc_cnt_reg + 5'h01;
         osc_reg           <= osc_wrap ? ~osc_reg : osc_reg;
         pin_prev_reg      <= link.clk_pin;
         // Drive is dropped while the pin is an input so the host owns it alone
         link.dev_clk_out  <= osc_reg & osc_drive;
         link.dev_clk_oe_n <= ~osc_drive;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Modulator divider: 512 kHz by 4, 2.048 MHz by 16, both land on 128 kHz
   logic [4:0] div_cnt_reg;
   logic [4:0] div_ratio;
   logic       div_done;
   logic       mod_tick_w;

   assign div_ratio  = electrode_status_reg[`SDC_ESTAT_DIV_BIT] ? `SDC_DIV_HI : `SDC_DIV_LO;
   assign div_done   = (div_cnt_reg >= div_ratio - 5'h01);
   assign mod_tick_w = master_edge & div_done;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_cnt_reg    <= 5'h00;
         modulator_tick <= 1'b0;
      end
      else
      begin
         modulator_tick <= mod_tick_w;
         if (master_edge)
            div_cnt_reg <= div_done ? 5'h00 : div_cnt_reg + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sinc3 decimators: three integrators at the modulator rate, three
   // differentiators at the output rate, giving ((1-z^-N)/(1-z^-1))^3
   sdc_pkg::sdc_acc_t integ1_reg [2];
   sdc_pkg::sdc_acc_t integ2_reg [2];
   sdc_pkg::sdc_acc_t integ3_reg [2];
   sdc_pkg::sdc_acc_t dly1_reg   [2];
   sdc_pkg::sdc_acc_t dly2_reg   [2];
   sdc_pkg::sdc_acc_t dly3_reg   [2];
   sdc_pkg::sdc_acc_t comb1      [2];
   sdc_pkg::sdc_acc_t comb2      [2];
   sdc_pkg::sdc_acc_t comb3      [2];
   sdc_pkg::sdc_acc_t sample_in  [2];
   logic [10:0]       dec_cnt_reg;
   logic [10:0]       dec_ratio;
   logic              dec_point;
   logic              start_prev_reg;
   logic              start_rise;
   logic              running;
   logic [1:0]        settle_cnt_reg;

   assign dec_ratio  = sdc_dec_ratio(global_setup_reg_a[`SDC_A_RATE_LSB +: 3]);
   assign start_rise = link.start & ~start_prev_reg;
   assign running    = link.start & ~start_rise;
   // Ratio may shrink mid-count, so compare with >= to avoid a long wrap
   assign dec_point  = running & mod_tick_w & (dec_cnt_reg >= dec_ratio - 11'h001);

   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         sample_in[c] = mod_bits[c] ? 32'sh00000001 : 32'shffffffff;
         comb1[c]     = integ3_reg[c] - dly1_reg[c];
         comb2[c]     = comb1[c] - dly2_reg[c];
         comb3[c]     = comb2[c] - dly3_reg[c];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int c = 0; c < 2; c++)
         begin
            integ1_reg[c] <= 32'sh0;
            integ2_reg[c] <= 32'sh0;
            integ3_reg[c] <= 32'sh0;
            dly1_reg[c]   <= 32'sh0;
            dly2_reg[c]   <= 32'sh0;
            dly3_reg[c]   <= 32'sh0;
         end
      end
      else if (start_rise)
      begin
         // A fresh start empties the filter so settling is deterministic
         for (int c = 0; c < 2; c++)
         begin
            integ1_reg[c] <= 32'sh0;
            integ2_reg[c] <= 32'sh0;
            integ3_reg[c] <= 32'sh0;
            dly1_reg[c]   <= 32'sh0;
            dly2_reg[c]   <= 32'sh0;
            dly3_reg[c]   <= 32'sh0;
         end
      end
      else
      begin
         for (int c = 0; c < 2; c++)
         begin
            if (running && mod_tick_w)
            begin
               integ1_reg[c] <= integ1_reg[c] + sample_in[c];
               integ2_reg[c] <= integ2_reg[c] + integ1_reg[c];
               integ3_reg[c] <= integ3_reg[c] + integ2_reg[c];
            end
            if (dec_point)
            begin
               dly1_reg[c] <= integ3_reg[c];
               dly2_reg[c] <= comb1[c];
               dly3_reg[c] <= comb2[c];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output words, held back until the filter has settled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_prev_reg  <= 1'b0;
         dec_cnt_reg     <= 11'h000;
         settle_cnt_reg  <= 2'h0;
         link.data_ready <= 1'b0;
         link.ch0_word   <= 24'h000000;
         link.ch1_word   <= 24'h000000;
      end
      else
      begin
         start_prev_reg  <= link.start;
         link.data_ready <= 1'b0;
         if (!running)
         begin
            dec_cnt_reg    <= 11'h000;
            settle_cnt_reg <= 2'h0;
         end
         else if (mod_tick_w)
            dec_cnt_reg <= dec_point ? 11'h000 : dec_cnt_reg + 11'h001;
         if (dec_point)
         begin
            if (settle_cnt_reg < `SDC_SETTLE_OUT)
               settle_cnt_reg <= settle_cnt_reg + 2'h1;
            else
            begin
               link.data_ready <= 1'b1;
               link.ch0_word   <= sdc_clip(comb3[0]);
               link.ch1_word   <= sdc_clip(comb3[1]);
            end
         end
      end
   end

endmodule : sdc_dev_end

//--- hw/sdc_host_end.sv
// Host controller: APB slave registers, device register sequencer, external
// clock generator and output word capture.
// Assumes APB master on pclk; supply_is_5v is a static board level.
`include "sdc_params.svh"

module sdc_host_end
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   sdc_link_if.host         link,
   input  wire logic        supply_is_5v,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   ////////////////////////////////////////////////////////////////////////////////
   logic [3:0]              ctrl_reg;
   logic [7:0]              rdata_reg;
   logic [15:0]             count_reg;
   sdc_pkg::sdc_word_t      data0_reg;
   sdc_pkg::sdc_word_t      data1_reg;
   sdc_pkg::sdc_host_state_t state_reg;
   logic [7:0]              gap_reg;
   logic [4:0]              ext_cnt_reg;
   logic                    ext_clk_reg;
   logic                    wr_reg;
   logic                    rd_reg;
   logic [3:0]              addr_reg;
   logic [7:0]              wdata_reg;
   logic                    setup_w;
   logic                    access_w;
   logic                    cmd_w;
   logic                    hit_w;
   logic [31:0]             rd_mux;
   logic [7:0]              safe_data;
   logic [4:0]              ext_half;
   logic                    ext_run;

   assign setup_w  = psel & ~penable;
   assign access_w = psel & penable & pready & pwrite;
   assign cmd_w    = access_w & (paddr == `SDC_APB_CMD) & (state_reg == sdc_pkg::h_idle);
   assign hit_w    = (paddr == `SDC_APB_CTRL) | (paddr == `SDC_APB_CMD) |
                     (paddr == `SDC_APB_STATUS) | (paddr == `SDC_APB_DATA0) |
                     (paddr == `SDC_APB_DATA1);
   assign rd_mux   = (paddr == `SDC_APB_CTRL)   ? {28'h0, ctrl_reg} :
                     (paddr == `SDC_APB_STATUS) ? {count_reg, rdata_reg, 7'h00,
                                                   state_reg != sdc_pkg::h_idle} :
                     (paddr == `SDC_APB_DATA0)  ? {{8{data0_reg[23]}}, data0_reg} :
                     (paddr == `SDC_APB_DATA1)  ? {{8{data1_reg[23]}}, data1_reg} : 32'h0;
   // Never let software raise the high reference on a 3 V supply
   assign safe_data = (pwdata[11:8] == `SDC_IDX_SETUP_B && !supply_is_5v) ?
                      (pwdata[7:0] & ~(8'h01 << `SDC_B_HIREF_BIT)) : pwdata[7:0];
   assign ext_half  = ctrl_reg[`SDC_CTRL_EXT_FAST] ? 5'(`SDC_EXT_HALF_HI) : 5'(`SDC_EXT_HALF_LO);
   // Clock only runs when enabled and the device expects an external source
   assign ext_run   = ctrl_reg[`SDC_CTRL_EXT_RUN] & ~ctrl_reg[`SDC_CTRL_CLOCK_SOURCE_SELECT_PIN];

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave, one wait-free access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready   <= 1'b0;
         prdata   <= 32'h0;
         pslverr  <= 1'b0;
         ctrl_reg <= 4'h0;
      end
      else
      begin
         pready  <= setup_w;
         prdata  <= setup_w ? rd_mux : 32'h0;
         pslverr <= setup_w & ~hit_w;
         if (access_w && paddr == `SDC_APB_CTRL)
         begin
            ctrl_reg <= pwdata[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Device register sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= sdc_pkg::h_idle;
         wr_reg    <= 1'b0;
         rd_reg    <= 1'b0;
         addr_reg  <= 4'h0;
         wdata_reg <= 8'h00;
         rdata_reg <= 8'h00;
         gap_reg   <= 8'h00;
      end
      else
      begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         case (state_reg)
            sdc_pkg::h_idle:
            begin
               if (cmd_w)
               begin
                  wr_reg    <= ~pwdata[`SDC_CMD_READ_BIT];
                  rd_reg    <= pwdata[`SDC_CMD_READ_BIT];
                  addr_reg  <= pwdata[11:8];
                  wdata_reg <= safe_data;
                  state_reg <= sdc_pkg::h_wait;
               end
            end
            sdc_pkg::h_wait:
            begin
               if (link.reg_ack)
               begin
                  rdata_reg <= link.reg_rdata;
                  gap_reg   <= ctrl_reg[`SDC_CTRL_EXT_FAST] ? 8'(`SDC_GAP_HI_CYC) :
                                                              8'(`SDC_GAP_LO_CYC);
                  state_reg <= sdc_pkg::h_gap;
               end
            end
            sdc_pkg::h_gap:
            begin
               gap_reg <= gap_reg - 8'h01;
               if (gap_reg <= 8'h01)
               begin
                  state_reg <= sdc_pkg::h_idle;
               end
            end
            default:
            begin
               state_reg <= sdc_pkg::h_idle;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // External master clock and word capture
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_cnt_reg <= 5'h00;
         ext_clk_reg <= 1'b0;
         count_reg   <= 16'h0000;
         data0_reg   <= 24'h000000;
         data1_reg   <= 24'h000000;
      end
      else
      begin
         if (!ext_run)
         begin
            ext_cnt_reg <= 5'h00;
            ext_clk_reg <= 1'b0;
         end
         else if (ext_cnt_reg >= ext_half - 5'h01)
         begin
            ext_cnt_reg <= 5'h00;
            ext_clk_reg <= ~ext_clk_reg;
         end
         else
         begin
            ext_cnt_reg <= ext_cnt_reg + 5'h01;
         end
         if (link.data_ready)
         begin
            data0_reg <= link.ch0_word;
            data1_reg <= link.ch1_word;
            count_reg <= count_reg + 16'h0001;
         end
      end
   end

   assign link.clock_source_select_pin = ctrl_reg[`SDC_CTRL_CLOCK_SOURCE_SELECT_PIN];
   assign link.start                   = ctrl_reg[`SDC_CTRL_START];
   assign link.reg_wr                  = wr_reg;
   assign link.reg_rd                  = rd_reg;
   assign link.reg_addr                = addr_reg;
   assign link.reg_wdata               = wdata_reg;
   assign link.host_clk_out            = ext_clk_reg;
   assign link.host_clk_oe_n           = ~ext_run;

endmodule : sdc_host_end

//--- verif/sdc_link_assertions.sv
// Checker of the link between host end and converter core.
// Assumes one pclk domain; it sees only the link signals.
module sdc_link_assertions
(
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               clock_source_select_pin,
   input wire logic               start,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic               reg_ack,
   input wire logic               data_ready,
   input wire sdc_pkg::sdc_word_t ch0_word,
   input wire logic               dev_clk_out,
   input wire logic               dev_clk_oe_n
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   sequence req_s;
      reg_wr || reg_rd;
   endsequence
   sequence ack_s;
      ##1 reg_ack ##1 !reg_ack;
   endsequence
   ack_after_req_a: assert property (req_s |-> ack_s)
      else $error("link ack missing");
   ack_has_req_a: assert property (reg_ack |-> $past(reg_wr) || $past(reg_rd))
      else $error("stray link ack");
   // Enable is registered, so it follows the select pin one cycle late
   ext_pin_in_a: assert property (!clock_source_select_pin && !$past(clock_source_select_pin)
      |-> dev_clk_oe_n)
      else $error("core drives clock pin on external clock");
   osc_drive_a: assert property (!dev_clk_oe_n |-> $past(clock_source_select_pin))
      else $error("clock pin driven without oscillator");
   osc_quiet_a: assert property (dev_clk_oe_n |-> !dev_clk_out)
      else $error("oscillator output not low");
   word_hold_a: assert property ($changed(ch0_word) |-> data_ready)
      else $error("word changed without data ready");
   ready_pulse_a: assert property (data_ready |=> !data_ready)
      else $error("data ready longer than one cycle");
   settle_gap_a: assert property ($rose(start) |=> !data_ready [*8])
      else $error("output too soon after start");
   ready_start_a: assert property (data_ready |-> $past(start))
      else $error("output without start");
endmodule : sdc_link_assertions

//--- verif/tb_sigma_delta_decimation_clocking.sv
// Bench: APB calls into the host end, which drives the converter core over the link.
// Assumes the designer's APB map, device register indices and rate encoding.
`include "sdc_params.svh"
module tb_sigma_delta_decimation_clocking;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, pready, pslverr, tick, ref_pd, ref_hi;
   logic        presetn = 1'b0, supply_is_5v = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [1:0]  mod_bits = 2'b01;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int          errors, total_checks, cyc, n;
   sdc_link_if link();
   sdc_dev_end sdc_dev_end_inst (.pclk(pclk), .presetn(presetn), .link(link), .mod_bits(mod_bits),
      .modulator_tick(tick), .reference_buffer_powerdown(ref_pd), .high_reference_select(ref_hi));
   sdc_host_end sdc_host_end_inst (.pclk(pclk), .presetn(presetn), .link(link),
      .supply_is_5v(supply_is_5v), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   sdc_link_assertions sdc_link_assertions_inst (.pclk(pclk), .presetn(presetn),
      .clock_source_select_pin(link.clock_source_select_pin), .start(link.start),
      .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_ack(link.reg_ack),
      .data_ready(link.data_ready), .ch0_word(link.ch0_word), .dev_clk_out(link.dev_clk_out),
      .dev_clk_oe_n(link.dev_clk_oe_n));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         errors++;
         summarize();
      end
   end
   task automatic summarize();
      if (errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Called just after a rising edge; holds the request until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = pslverr ? 32'hffffffff : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic dev(input logic [12:0] c);
      apb(1'b1, `SDC_APB_CMD, {19'h0, c});
      do
         apb(1'b0, `SDC_APB_STATUS, 32'h0);
      while (rd[0] !== 1'b0);
   endtask : dev
   // Skips two ticks first so a divider or source change has settled
   task automatic span(input logic [31:0] e);
      repeat (2)
         do
            @(posedge pclk);
         while (tick !== 1'b1);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (tick !== 1'b1);
      chk(n, e);
   endtask : span
   task automatic ticks();
      n = 0;
      do
      begin
         @(posedge pclk);
         n += int'(tick);
      end
      while (link.data_ready !== 1'b1);
   endtask : ticks
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      dev(13'h1200);
      chk(rd[15:8], 8'h80);
      chk(ref_pd, 1'b1);
      dev(13'h1800);
      chk(rd[15:8], 8'h00);
      apb(1'b1, `SDC_APB_CTRL, 32'h2);
      span(72);
      chk(link.dev_clk_oe_n, 1'b1);
      dev(13'h0230);
      chk({ref_pd, ref_hi, link.dev_clk_oe_n}, 3'b010);
      supply_is_5v <= 1'b0;
      dev(13'h0230);
      chk(ref_hi, 1'b0);
      dev(13'h0840);
      apb(1'b1, `SDC_APB_CTRL, 32'hc);
      span(64);
      chk(link.dev_clk_oe_n, 1'b1);
      dev(13'h0800);
      apb(1'b1, `SDC_APB_CTRL, 32'h4);
      span(72);
      dev(13'h0107);
      apb(1'b1, `SDC_APB_CTRL, 32'h5);
      ticks();
      chk(n >= 31 && n <= 33, 1'b1);
      ticks();
      chk(n, 8);
      apb(1'b0, `SDC_APB_DATA0, 32'h0);
      chk(rd, 32'h200);
      apb(1'b0, `SDC_APB_DATA1, 32'h0);
      chk(rd, 32'hfffffe00);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'hffffffff);
      summarize();
   end
endmodule : tb_sigma_delta_decimation_clocking
